// >>> core/pvo_cfg.svh
// register offsets, field positions and reset values of the video output mapper
`ifndef PVO_CFG_SVH
`define PVO_CFG_SVH
`define PVO_ADDR_POL 16'h4708
`define PVO_ADDR_ORDER 16'h4709
`define PVO_ADDR_BYP_HI 16'h470a
`define PVO_ADDR_BYP_LO 16'h470b
`define PVO_ADDR_BYP_CTL 16'h470c
`define PVO_ADDR_LV_SEL 16'h470d
`define PVO_RST_POL 8'h01
`define PVO_RST_ORDER 8'h00
`define PVO_RST_BYP 8'h00
`define PVO_RST_LV_SEL 3'h0
`define PVO_POL_PCLK 0
`define PVO_POL_VSYNC 1
`define PVO_POL_HREF 2
`define PVO_ORD_PAT_EN 0
`define PVO_ORD_PAT_SEL_LSB 1
`define PVO_ORD_REPEAT 3
`define PVO_ORD_SWAP_LSB 4
`define PVO_BYP_CTL_MASK 8'h1f
`define PVO_PAT8_LAST 4'h9
`define PVO_PAT10_LAST 4'hb
`define PVO_BUF_W 12
`define PVO_BUF_DEPTH 2
`endif

// >>> core/pvo_pkg.sv
// shared types of the video output mapper
package pvo_pkg;
	typedef enum logic [1:0] {
		PVO_PAT_DBG0 = 2'h0,
		PVO_PAT_W8 = 2'h1,
		PVO_PAT_W10 = 2'h2,
		PVO_PAT_DBG3 = 2'h3
	} pvo_pat_t;
	typedef enum logic [2:0] {
		PVO_LV_COMB = 3'h0,
		PVO_LV_HALF = 3'h1,
		PVO_LV_WIN1 = 3'h2,
		PVO_LV_WIN2 = 3'h3,
		PVO_LV_WIN3 = 3'h4
	} pvo_lv_t;
endpackage

// >>> core/pvo_mapper.sv
// parallel video output mapper: bit order, walking-one pattern, line-valid select
// Functional notes
// [RL1] Order code 000 sends data bit n to pin n, and code 001 reverses all ten bits.
// [RL2] Code 010 puts bits 2..9 on pins 9..2 with bits 1:0 straight; code 011 sends {d[7:0],d[9:8]}.
// [RL3] Code 100 keeps bits 9:8 and reverses bits 7:0; code 101 keeps bit 9 and reverses bits 8:0.
// [RL4] Code 110 reverses bits 9:1 over pins 9..1 with bit 0 straight; code 111 sends {d[8:0],d[9]}.
// [RL5] Bit 0 of the order register switches the walking-one generator on in place of video.
// [RL6] Pattern select 01 walks 0x00, 0x01 up to 0x80, then 0xff on the eight upper pins, repeating.
// [RL7] Pattern select 10 walks 0x000, 0x001 up to 0x200, then 0x3ff on all ten pins, repeating.
// [RL8] Software uses select 01 or 10; 00 and 11 are debug settings only.
// [RL9] Repeat bit 3 makes every pattern value appear twice in a row before advancing.
// [RL10] Line-valid select 000 routes the combined line valid and 001 the half-scale one.
// [RL11] Line-valid select 010, 011 and 100 route window 1, 2 and 3 line valid.
// [RL12] A 16-bit bypass enable is held, high byte at the lower address, low byte at the next.
// [RL13] Bypass control holds a 4-bit path select in bits 3:0 and a debug bit 4; bits 7:5 read 0.
// [RL14] Control bits invert line valid and frame sync outputs, and one sets pixel clock polarity.
// [RL15] The generator steps once per output pixel clock and wraps from all ones to all zeros.
// [RL16] Line-valid select codes 101 to 111 fall back to the combined line valid.
`timescale 1ns/100ps
`include "pvo_cfg.svh"
module pvo_mapper import pvo_pkg::*; (
	input wire logic clk, // core clock, 40 MHz
	input wire logic resetn, // synchronous reset, active low
	input wire logic [15:0] reg_addr, // control register address
	input wire logic [7:0] reg_wdata, // write byte
	input wire logic reg_wr, // write strobe, one cycle
	input wire logic reg_rd, // read strobe, one cycle
	output logic [7:0] reg_rdata, // read byte, one cycle after reg_rd
	output logic reg_rvalid, // read answer strobe
	input wire logic [9:0] vid_data, // pixel from the core
	input wire logic vid_valid, // pixel offered
	output logic vid_ready, // buffer can take a pixel
	input wire logic vid_frame_sync, // frame sync with the pixel
	input wire logic lv_comb, // combined line valid
	input wire logic lv_half, // half-scale line valid
	input wire logic lv_win1, // window 1 line valid
	input wire logic lv_win2, // window 2 line valid
	input wire logic lv_win3, // window 3 line valid
	input wire logic pix_clk_in, // pixel clock, foreign domain
	input wire logic rx_stall, // receiver stall, foreign domain
	output logic [9:0] dvp_data, // data pins
	output logic dvp_href, // horizontal reference pin
	output logic dvp_vsync, // frame sync pin
	output logic dvp_pclk // pixel clock pin
);
	logic [7:0] pol_reg;
	logic [7:0] order_reg;
	logic [7:0] byp_hi;
	logic [7:0] byp_lo;
	logic [7:0] byp_ctl;
	logic [2:0] lv_sel;
	logic [2:0] swap;
	logic pat_on;
	logic rep_on;
	pvo_pat_t pat_sel;
	logic pclk_s1, pclk_s2, pclk_s3;
	logic stall_s1, stall_s2;
	logic pix_edge;
	logic out_step;
	logic [`PVO_BUF_W-1:0] buf_mem [`PVO_BUF_DEPTH];
	logic wr_ptr, rd_ptr;
	logic [1:0] count;
	logic buf_empty;
	logic in_fire;
	logic pop;
	logic [9:0] head_data;
	logic head_href;
	logic head_vsync;
	logic lv_pick;
	logic [9:0] rev;
	logic [9:0] next_mapped;
	logic [3:0] pat_idx;
	logic pat_phase;
	logic [3:0] pat_last;
	logic [9:0] next_pat;

	assign swap = order_reg[`PVO_ORD_SWAP_LSB +: 3];
	assign pat_on = order_reg[`PVO_ORD_PAT_EN]; // RL5
	assign rep_on = order_reg[`PVO_ORD_REPEAT];
	assign pat_sel = pvo_pat_t'(order_reg[`PVO_ORD_PAT_SEL_LSB +: 2]);

	// register writes; only bypass control and line-valid select drop their unimplemented bits
	always_ff @(posedge clk) begin
		if (!resetn) begin
			pol_reg <= `PVO_RST_POL;
			order_reg <= `PVO_RST_ORDER;
			byp_hi <= `PVO_RST_BYP;
			byp_lo <= `PVO_RST_BYP;
			byp_ctl <= `PVO_RST_BYP;
			lv_sel <= `PVO_RST_LV_SEL;
		end else if (reg_wr) begin
			if (reg_addr == `PVO_ADDR_POL) begin
				pol_reg <= reg_wdata;
			end else if (reg_addr == `PVO_ADDR_ORDER) begin
				order_reg <= reg_wdata;
			end else if (reg_addr == `PVO_ADDR_BYP_HI) begin
				byp_hi <= reg_wdata; // RL12
			end else if (reg_addr == `PVO_ADDR_BYP_LO) begin
				byp_lo <= reg_wdata; // RL12
			end else if (reg_addr == `PVO_ADDR_BYP_CTL) begin
				byp_ctl <= reg_wdata & `PVO_BYP_CTL_MASK; // RL13
			end else if (reg_addr == `PVO_ADDR_LV_SEL) begin
				lv_sel <= reg_wdata[2:0];
			end
		end
	end

	// register reads; unmapped addresses answer zero
	always_ff @(posedge clk) begin
		if (!resetn) begin
			reg_rdata <= 8'h00;
			reg_rvalid <= 1'b0;
		end else begin
			reg_rvalid <= reg_rd;
			if (!reg_rd) begin
				reg_rdata <= 8'h00;
			end else if (reg_addr == `PVO_ADDR_POL) begin
				reg_rdata <= pol_reg;
			end else if (reg_addr == `PVO_ADDR_ORDER) begin
				reg_rdata <= order_reg;
			end else if (reg_addr == `PVO_ADDR_BYP_HI) begin
				reg_rdata <= byp_hi;
			end else if (reg_addr == `PVO_ADDR_BYP_LO) begin
				reg_rdata <= byp_lo;
			end else if (reg_addr == `PVO_ADDR_BYP_CTL) begin
				reg_rdata <= byp_ctl; // RL13
			end else if (reg_addr == `PVO_ADDR_LV_SEL) begin
				reg_rdata <= {5'h00, lv_sel};
			end else begin
				reg_rdata <= 8'h00;
			end
		end
	end

	// pixel clock pin crosses in through three flops, stall pin through two
	always_ff @(posedge clk) begin
		if (!resetn) begin
			pclk_s1 <= 1'b0;
			pclk_s2 <= 1'b0;
			pclk_s3 <= 1'b0;
			stall_s1 <= 1'b0;
			stall_s2 <= 1'b0;
		end else begin
			pclk_s1 <= pix_clk_in;
			pclk_s2 <= pclk_s1;
			pclk_s3 <= pclk_s2;
			stall_s1 <= rx_stall;
			stall_s2 <= stall_s1;
		end
	end

	// one output slot per pixel clock rise unless the receiver stalls
	assign pix_edge = pclk_s2 & ~pclk_s3;
	assign out_step = pix_edge & ~stall_s2;

	// line-valid source choice, taken when the pixel enters the buffer
	always_comb begin
		case (lv_sel)
			PVO_LV_COMB: lv_pick = lv_comb; // RL10
			PVO_LV_HALF: lv_pick = lv_half; // RL10
			PVO_LV_WIN1: lv_pick = lv_win1; // RL11
			PVO_LV_WIN2: lv_pick = lv_win2; // RL11
			PVO_LV_WIN3: lv_pick = lv_win3; // RL11
			default: lv_pick = lv_comb; // RL16
		endcase
	end

	// two-entry buffer; a stalled receiver backs up into vid_ready
	assign buf_empty = (count == 2'd0);
	assign vid_ready = (count != 2'd2);
	assign in_fire = vid_valid & vid_ready;
	assign pop = out_step & ~buf_empty;
	assign head_data = buf_mem[rd_ptr][9:0];
	assign head_href = buf_mem[rd_ptr][10];
	assign head_vsync = buf_mem[rd_ptr][11];
	always_ff @(posedge clk) begin
		if (!resetn) begin
			wr_ptr <= 1'b0;
			rd_ptr <= 1'b0;
			count <= 2'd0;
			buf_mem[0] <= '0;
			buf_mem[1] <= '0;
		end else begin
			if (in_fire) begin
				buf_mem[wr_ptr] <= {vid_frame_sync, lv_pick, vid_data};
				wr_ptr <= ~wr_ptr;
			end
			if (pop) begin
				rd_ptr <= ~rd_ptr;
			end
			count <= count + {1'b0, in_fire} - {1'b0, pop};
		end
	end

	// full bit reversal, the base of orders 001, 010, 100, 101 and 110
	genvar gi;
	generate
		for (gi = 0; gi < 10; gi++) begin : g_rev
			assign rev[gi] = head_data[9 - gi];
		end
	endgenerate

	// bit order onto the pins
	always_comb begin
		case (swap)
			3'h0: next_mapped = head_data; // RL1
			3'h1: next_mapped = rev; // RL1
			3'h2: next_mapped = {rev[7:0], head_data[1:0]}; // RL2
			3'h3: next_mapped = {head_data[7:0], head_data[9:8]}; // RL2
			3'h4: next_mapped = {head_data[9:8], rev[9:2]}; // RL3
			3'h5: next_mapped = {head_data[9], rev[9:1]}; // RL3
			3'h6: next_mapped = {rev[8:0], head_data[0]}; // RL4
			default: next_mapped = {head_data[8:0], head_data[9]}; // RL4
		endcase
	end

	// walking-one value from the step index
	assign pat_last = (pat_sel == PVO_PAT_W10) ? `PVO_PAT10_LAST : `PVO_PAT8_LAST;
	always_comb begin
		next_pat = 10'h000;
		case (pat_sel)
			PVO_PAT_W8: begin
				if (pat_idx >= pat_last) begin
					next_pat = 10'h3fc; // RL6
				end else if (pat_idx != 4'h0) begin
					next_pat = {8'(8'h01 << (pat_idx - 4'h1)), 2'b00}; // RL6
				end
			end
			PVO_PAT_W10: begin
				if (pat_idx >= pat_last) begin
					next_pat = 10'h3ff; // RL7
				end else if (pat_idx != 4'h0) begin
					next_pat = 10'(10'h001 << (pat_idx - 4'h1)); // RL7
				end
			end
			default: next_pat = 10'h000; // RL8
		endcase
	end

	// generator steps per output slot; repeat holds each value one extra slot
	always_ff @(posedge clk) begin
		if (!resetn || !pat_on) begin
			pat_idx <= 4'h0;
			pat_phase <= 1'b0;
		end else if (out_step) begin
			if (rep_on && !pat_phase) begin
				pat_phase <= 1'b1; // RL9
			end else begin
				pat_phase <= 1'b0;
				pat_idx <= (pat_idx >= pat_last) ? 4'h0 : pat_idx + 4'h1; // RL15
			end
		end
	end

	// pin registers; an empty buffer holds the last pixel rather than glitching
	always_ff @(posedge clk) begin
		if (!resetn) begin
			dvp_data <= 10'h000;
			dvp_href <= 1'b0;
			dvp_vsync <= 1'b0;
		end else if (out_step && pat_on) begin
			dvp_data <= next_pat; // RL5
		end else if (pop) begin
			dvp_data <= next_mapped;
			dvp_href <= head_href ^ pol_reg[`PVO_POL_HREF]; // RL14
			dvp_vsync <= head_vsync ^ pol_reg[`PVO_POL_VSYNC]; // RL14
		end
	end

	// pixel clock out follows the synchronised input, one core cycle late
	always_ff @(posedge clk) begin
		if (!resetn) begin
			dvp_pclk <= 1'b0;
		end else begin
			dvp_pclk <= pclk_s3 ^ pol_reg[`PVO_POL_PCLK]; // RL14
		end
	end

	swap_ident_a: // RL1
	assert property (@(posedge clk) disable iff (!resetn)
		pop && !pat_on && swap == 3'h0 |=> dvp_data == $past(head_data))
		else $error("straight order broken");
	swap_rev_a: // RL1
	assert property (@(posedge clk) disable iff (!resetn)
		pop && !pat_on && swap == 3'h1 |=>
		dvp_data[0] == $past(head_data[9]) && dvp_data[9] == $past(head_data[0]))
		else $error("reversed order broken");
	swap_rot_a: // RL2
	assert property (@(posedge clk) disable iff (!resetn)
		pop && !pat_on && swap == 3'h3 |=>
		dvp_data == {$past(head_data[7:0]), $past(head_data[9:8])})
		else $error("order 011 broken");
	swap_low_a: // RL3
	assert property (@(posedge clk) disable iff (!resetn)
		pop && !pat_on && swap == 3'h4 |=>
		dvp_data[9:8] == $past(head_data[9:8]) && dvp_data[7] == $past(head_data[0]))
		else $error("order 100 broken");
	swap_top_a: // RL4
	assert property (@(posedge clk) disable iff (!resetn)
		pop && !pat_on && swap == 3'h7 |=>
		dvp_data == {$past(head_data[8:0]), $past(head_data[9])})
		else $error("order 111 broken");
	pat8_wrap_a: // RL6
	assert property (@(posedge clk) disable iff (!resetn)
		out_step && pat_on && pat_sel == PVO_PAT_W8 && !rep_on && pat_idx == 4'h9 |=>
		dvp_data == 10'h3fc && pat_idx == 4'h0)
		else $error("8-bit walk end broken");
	pat10_wrap_a: // RL7
	assert property (@(posedge clk) disable iff (!resetn)
		out_step && pat_on && pat_sel == PVO_PAT_W10 && !rep_on && pat_idx == 4'hb |=>
		dvp_data == 10'h3ff && pat_idx == 4'h0)
		else $error("10-bit walk end broken");
	pat_hold_a: // RL9
	assert property (@(posedge clk) disable iff (!resetn)
		out_step && pat_on && rep_on && !pat_phase |=> pat_idx == $past(pat_idx) && pat_phase)
		else $error("repeat did not hold value");
	lv_half_a: // RL10
	assert property (@(posedge clk) disable iff (!resetn)
		in_fire && buf_empty && lv_sel == 3'h1 |=> head_href == $past(lv_half))
		else $error("half-scale line valid not routed");
	lv_resv_a: // RL16
	assert property (@(posedge clk) disable iff (!resetn)
		in_fire && buf_empty && lv_sel >= 3'h5 |=> head_href == $past(lv_comb))
		else $error("reserved select not combined");
	href_pol_a: // RL14
	assert property (@(posedge clk) disable iff (!resetn)
		pop && !pat_on |=> dvp_href == ($past(head_href) ^ $past(pol_reg[2])))
		else $error("line valid polarity wrong");
	byp_hi_a: // RL12
	assert property (@(posedge clk) disable iff (!resetn)
		reg_wr && reg_addr == 16'h470a ##1 !reg_wr ##1 reg_rd && reg_addr == 16'h470a && !reg_wr
		|=> reg_rdata == $past(reg_wdata, 3))
		else $error("bypass high byte lost");
	byp_unused_a: // RL13
	assert property (@(posedge clk) disable iff (!resetn)
		reg_rd && reg_addr == 16'h470c |=> reg_rdata[7:5] == 3'h0 && reg_rvalid)
		else $error("bypass control unused bits set");
endmodule

// >>> dv/pvo_host.sv
// host side model: pixel clock source, stall driver and pin sampler
`timescale 1ns/100ps
module pvo_host (
	input wire logic clk, // core clock
	input wire logic [9:0] dvp_data, // data pins
	input wire logic dvp_href, // line valid pin
	input wire logic dvp_vsync, // frame sync pin
	input wire logic dvp_pclk, // pixel clock pin
	output logic pix_clk_in, // pixel clock to the device
	output logic rx_stall // stall request, set by the bench
);
	logic pclk_q = 1'b0;
	logic [11:0] q[$];
	// phase unrelated to clk, 200 ns period
	initial begin
		pix_clk_in = 1'b0;
		#7;
		forever #100 pix_clk_in = ~pix_clk_in;
	end
	// sample on the falling pin edge, midway between data updates
	always @(posedge clk) begin
		pclk_q <= dvp_pclk;
		if (pclk_q && !dvp_pclk)
			q.push_back({dvp_vsync, dvp_href, dvp_data});
	end
endmodule

// >>> dv/pvo_mapper_tb.sv
// self-checking bench of the video output mapper
`timescale 1ns/100ps
`include "pvo_cfg.svh"
module pvo_mapper_tb;
	logic clk, resetn, reg_wr, reg_rd, vid_valid, fs, reg_rvalid, vid_ready;
	logic [15:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata;
	logic [9:0] vid_data, dvp_data;
	logic [4:0] lv;
	logic pix_clk_in, rx_stall, dvp_href, dvp_vsync, dvp_pclk;
	int num_errors = 0;
	int n_checks = 0;
	logic [15:0] adr[6] = '{`PVO_ADDR_POL, `PVO_ADDR_ORDER, `PVO_ADDR_BYP_HI,
		`PVO_ADDR_BYP_LO, `PVO_ADDR_BYP_CTL, `PVO_ADDR_LV_SEL};
	logic [7:0] rstv[6] = '{8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
	logic [7:0] msk[6] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'h1f, 8'h07};
	pvo_mapper uut (.clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
		.vid_data(vid_data), .vid_valid(vid_valid), .vid_ready(vid_ready),
		.vid_frame_sync(fs), .lv_comb(lv[0]), .lv_half(lv[1]), .lv_win1(lv[2]),
		.lv_win2(lv[3]), .lv_win3(lv[4]), .pix_clk_in(pix_clk_in), .rx_stall(rx_stall),
		.dvp_data(dvp_data), .dvp_href(dvp_href), .dvp_vsync(dvp_vsync), .dvp_pclk(dvp_pclk));
	pvo_host host (.clk(clk), .dvp_data(dvp_data), .dvp_href(dvp_href),
		.dvp_vsync(dvp_vsync), .dvp_pclk(dvp_pclk), .pix_clk_in(pix_clk_in),
		.rx_stall(rx_stall));
	// 40 MHz core clock
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	task automatic wrap_up();
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic check(input logic [11:0] seen, input logic [11:0] exp);
		n_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic fail_out();
		num_errors++;
		wrap_up();
	endtask
	// pixel clock pin repeats the pin input three core clocks later
	task automatic pclk_chk(input logic inv);
		logic b;
		@(posedge clk);
		#1 b = pix_clk_in;
		repeat (3) @(posedge clk);
		#1 check({11'h0, dvp_pclk}, {11'h0, b ^ inv});
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk);
		#1 {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
		@(posedge clk);
		#1 reg_wr = 1'b0;
	endtask
	task automatic rd(input logic [15:0] a, input logic [7:0] e);
		@(posedge clk);
		#1 {reg_addr, reg_rd} = {a, 1'b1};
		@(posedge clk);
		#1 reg_rd = 1'b0;
		check({reg_rvalid, 3'h0, reg_rdata}, {4'h8, e});
	endtask
	// holds the pixel until the buffer takes it
	task automatic push(input logic [9:0] d);
		int n;
		n = 0;
		@(posedge clk);
		#1 {vid_data, vid_valid} = {d, 1'b1};
		while (!vid_ready && n < 500) begin
			@(posedge clk);
			#1 n++;
		end
		if (n == 500) fail_out();
		@(posedge clk);
		#1 vid_valid = 1'b0;
	endtask
	task automatic getq(output logic [11:0] v);
		int n;
		n = 0;
		while (host.q.size() == 0 && n < 200) begin
			@(posedge clk);
			n++;
		end
		if (n == 200) fail_out();
		v = host.q.pop_front();
	endtask
	// skip samples while (data equals val) matches eq
	task automatic skip(input logic [9:0] val, input logic eq, output logic [11:0] v);
		int n;
		n = 0;
		getq(v);
		while ((v[9:0] === val) == eq && n < 100) begin
			getq(v);
			n++;
		end
		if (n == 100) fail_out();
	endtask
	function automatic logic [9:0] mapd(input logic [2:0] c, input logic [9:0] d);
		logic [9:0] r;
		logic [7:0] a, b;
		logic [8:0] e, f;
		r = {<<{d}};
		a = {<<{d[9:2]}};
		b = {<<{d[7:0]}};
		e = {<<{d[8:0]}};
		f = {<<{d[9:1]}};
		case (c)
			3'h0: return d;
			3'h1: return r;
			3'h2: return {a, d[1:0]};
			3'h3: return {d[7:0], d[9:8]};
			3'h4: return {d[9:8], b};
			3'h5: return {d[9], e};
			3'h6: return {f, d[0]};
			default: return {d[8:0], d[9]};
		endcase
	endfunction
	function automatic logic [9:0] patv(input logic w10, input int k);
		logic [9:0] v;
		v = (k == 0) ? 10'h000 : (k == (w10 ? 11 : 9)) ? 10'h3ff : 10'h001 << (k - 1);
		return w10 ? v : {v[7:0], 2'h0};
	endfunction
	initial begin
		logic [11:0] v;
		logic [9:0] d, pv0, pv1;
		logic [7:0] wv;
		logic [2:0] c, s;
		logic [1:0] p;
		int i, k;
		void'($urandom(32'h56354b98));
		{resetn, reg_wr, reg_rd, vid_valid, fs, lv} = '0;
		host.rx_stall = 1'b0;
		{reg_addr, reg_wdata, vid_data} = '0;
		repeat (3) @(posedge clk);
		#1 resetn = 1'b1;
		// reset values, masks, unmapped place
		for (i = 0; i < 6; i++) rd(adr[i], rstv[i]);
		rd(16'h4700, 8'h00);
		pclk_chk(1'b1);
		for (i = 0; i < 6; i++) begin
			wv = 8'($urandom);
			wr(adr[i], wv);
			rd(adr[i], wv & msk[i]);
		end
		wr(16'h4700, 8'hff);
		rd(16'h4700, 8'h00);
		wr(`PVO_ADDR_POL, 8'h00);
		// bit order, line valid source and polarity, all codes then random
		for (i = 0; i < 32; i++) begin
			c = (i < 8) ? i[2:0] : 3'($urandom);
			s = (i < 8) ? i[2:0] : 3'($urandom);
			p = 2'($urandom);
			wr(`PVO_ADDR_POL, {5'h0, p, 1'b0});
			wr(`PVO_ADDR_ORDER, {1'b0, c, 4'h0});
			wr(`PVO_ADDR_LV_SEL, {5'h0, s});
			{lv, fs} = 6'($urandom);
			d = 10'($urandom) | 10'h001;
			push(d);
			repeat (24) @(posedge clk);
			host.q.delete();
			getq(v);
			check(v, {fs ^ p[0], (s <= 3'h4 ? lv[s] : lv[0]) ^ p[1], mapd(c, d)});
			pclk_chk(1'b0);
		end
		// stalled receiver: buffer fills, refuses, then drains in order
		wr(`PVO_ADDR_ORDER, 8'h00);
		host.rx_stall = 1'b1;
		repeat (6) @(posedge clk);
		pv0 = ~mapd(c, d);
		pv1 = pv0 ^ 10'($urandom | 1);
		push(pv0);
		push(pv1);
		check({11'h0, vid_ready}, 12'h000);
		host.rx_stall = 1'b0;
		skip(mapd(c, d), 1'b1, v);
		check({2'h0, v[9:0]}, {2'h0, pv0});
		skip(pv0, 1'b1, v);
		check({2'h0, v[9:0]}, {2'h0, pv1});
		check({11'h0, vid_ready}, 12'h001);
		// walking one, 8 and 10 bit, with and without repeat; only defined selects
		for (k = 0; k < 4; k++) begin
			wr(`PVO_ADDR_ORDER, {4'h0, k[1], k[0] ? 2'h2 : 2'h1, 1'b1});
			skip(patv(k[0], k[0] ? 11 : 9), 1'b0, v);
			skip(patv(k[0], k[0] ? 11 : 9), 1'b1, v);
			for (i = 0; i < (k[0] ? 12 : 10) * (k[1] + 1); i++) begin
				check({2'h0, v[9:0]}, {2'h0, patv(k[0], i >> k[1])});
				getq(v);
			end
		end
		wr(`PVO_ADDR_ORDER, 8'h00);
		wrap_up();
	end
endmodule
